// [tac_timer.sv]
// Single timer channel datapath with CPU access contention resolution.
// Assumes pins and count enables are synchronous to i_clk.
`timescale 1ns/1ns
module tac_timer
   import tac_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rstn,
   // CPU access port
   input wire logic i_req,
   input wire logic i_wr,
   input wire logic [1:0] i_sel,
   input wire logic [15:0] i_wdata,
   output logic [15:0] o_rdata,
   output logic o_done,
   // Counter control
   input wire logic i_run,
   input wire logic i_down,
   input wire logic i_int_tick,
   input wire logic [2:0] i_clk_sel,
   input wire logic i_capture_mode,
   input wire logic i_buffer_mode,
   input wire logic i_clear_on_match,
   input wire logic i_ovf_en,
   input wire logic i_unf_en,
   input wire logic i_match_en,
   input wire logic i_module_stop,
   input wire logic i_xfer_ack,
   // Shared pins: clock inputs and capture/compare pins
   input wire logic i_ch0_pin_c,
   input wire logic i_ch0_pin_d,
   input wire logic i_ch1_pin_b,
   input wire logic i_ch2_pin_b,
   input wire logic i_ch0_pin_c_cmp,
   output logic o_ch0_pin_c,
   output logic o_ch0_pin_c_oe,
   output logic o_match_irq,
   output logic o_ovf_irq,
   output logic o_unf_irq,
   output logic o_xfer_req
);
   tac_acc_if acc();
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic [15:0] gr_q;
   logic [15:0] gr_d;
   logic [15:0] buf_q;
   logic [15:0] buf_d;
   logic [2:0] flg_q;
   logic [2:0] flg_d;
   logic [2:0] flg_seen_q;
   logic [2:0] flg_seen_d;
   logic [15:0] rdata_q;
   logic ext_q;
   logic pin_c_q;
   logic pin_out_q;
   logic clk_ext;
   logic ext_rise;
   logic tick;
   logic wr_cnt;
   logic wr_gr;
   logic wr_buf;
   logic wr_flg;
   logic rd_flg;
   logic wrap_up;
   logic wrap_dn;
   logic match;
   logic cap;
   logic clr;
   logic ovf_set;
   logic unf_set;
   logic [15:0] cnt_step;
   logic [2:0] flg_clr;
   logic [2:0] flg_set;
   logic [15:0] gr_now;

   tac_acc_seq u_seq (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_req(i_req),
      .i_wr(i_wr),
      .i_sel(i_sel),
      .i_wdata(i_wdata),
      .o_done(o_done),
      .acc(acc)
   );

   // Pin sharing: the selected clock input is a capture/compare pin of its channel
   assign clk_ext = (i_clk_sel == TAC_CK_A) ? i_ch0_pin_c : // RULE9
                    (i_clk_sel == TAC_CK_B) ? i_ch0_pin_d :
                    (i_clk_sel == TAC_CK_C) ? i_ch1_pin_b :
                    (i_clk_sel == TAC_CK_D) ? i_ch2_pin_b : 1'b0;
   assign ext_rise = clk_ext & ~ext_q;
   assign tick = i_run & ~i_module_stop & ((i_clk_sel == TAC_CK_INT) ? i_int_tick : ext_rise);

   // Write commit strobes in the second access state; flag read strobe in the first
   assign wr_cnt = acc.t2 & acc.wr & (acc.sel == TAC_SEL_CNT);
   assign wr_gr = acc.t2 & acc.wr & (acc.sel == TAC_SEL_GR);
   assign wr_buf = acc.t2 & acc.wr & (acc.sel == TAC_SEL_BUF);
   assign wr_flg = acc.t2 & acc.wr & (acc.sel == TAC_SEL_FLG);
   assign rd_flg = acc.t1 & ~acc.wr & (acc.sel == TAC_SEL_FLG);

   // Event detection; capture uses channel 0 pin C rising edge
   // Own history for the capture pin, so another clock pin cannot fake an edge
   assign cap = i_capture_mode & ~i_module_stop & (i_clk_sel != TAC_CK_A) & i_ch0_pin_c & ~pin_c_q;
   assign match = ~i_capture_mode & tick & (cnt_q == gr_q) & ~wr_gr; // RULE2
   assign clr = i_clear_on_match & (match | cap);
   assign wrap_up = tick & ~i_down & (cnt_q == TAC_CNT_MAX);
   assign wrap_dn = tick & i_down & (cnt_q == TAC_CNT_RST);
   assign cnt_step = i_down ? (cnt_q - 16'h0001) : (cnt_q + 16'h0001);

   // Counter: clear, then CPU write, then count, all in one state
   always_comb begin
      if (clr) begin
         cnt_d = TAC_CNT_RST; // RULE15 RULE17
      end else if (wr_cnt) begin
         cnt_d = acc.wdata; // RULE1
      end else if (tick) begin
         cnt_d = cnt_step;
      end else begin
         cnt_d = cnt_q;
      end
   end

   // Overflow and underflow lose to clear and to a counter write
   assign ovf_set = wrap_up & ~clr & ~wr_cnt; // RULE7 RULE8 RULE14
   assign unf_set = wrap_dn & ~clr & ~wr_cnt; // RULE7 RULE8 RULE14

   // General register: capture beats CPU write; buffered match loads old buffer
   always_comb begin
      if (cap) begin
         gr_d = cnt_q; // RULE5
      end else if (wr_gr) begin
         gr_d = acc.wdata;
      end else if (match & i_buffer_mode) begin
         gr_d = buf_q; // RULE3
      end else begin
         gr_d = gr_q;
      end
   end

   // Buffer: capture transfer beats CPU write
   always_comb begin
      if (cap & i_buffer_mode) begin
         buf_d = gr_q; // RULE6
      end else if (wr_buf) begin
         buf_d = acc.wdata;
      end else begin
         buf_d = buf_q;
      end
   end

   // Flags: write zero clears only bits seen as one; set wins over clear
   assign flg_set = {unf_set, ovf_set, match | cap};
   assign flg_clr = (wr_flg ? (~acc.wdata[2:0] & flg_seen_q) : 3'h0) |
                    {2'h0, i_xfer_ack}; // RULE13
   assign flg_d = i_module_stop ? flg_q : ((flg_q & ~flg_clr) | flg_set); // RULE11
   assign flg_seen_d = rd_flg ? flg_q : (wr_flg ? 3'h0 : flg_seen_q);

   // Read data reflects a capture landing in the sample state
   assign gr_now = cap ? cnt_q : gr_q;
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         rdata_q <= 16'h0000;
      end else if (acc.t1 & ~acc.wr) begin
         case (acc.sel)
            TAC_SEL_CNT: rdata_q <= cnt_q;
            TAC_SEL_GR: rdata_q <= gr_now; // RULE4
            TAC_SEL_BUF: rdata_q <= (cap & i_buffer_mode) ? gr_q : buf_q;
            default: rdata_q <= {13'h0000, flg_q};
         endcase
      end
   end

   // State registers
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         cnt_q <= TAC_CNT_RST;
         gr_q <= TAC_GR_RST;
         buf_q <= TAC_GR_RST;
         flg_q <= 3'h0;
         flg_seen_q <= 3'h0;
         ext_q <= 1'b0;
         pin_c_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         gr_q <= gr_d;
         buf_q <= buf_d;
         flg_q <= flg_d;
         flg_seen_q <= flg_seen_d;
         ext_q <= clk_ext;
         pin_c_q <= i_ch0_pin_c;
      end
   end

   // Compare output toggles on match; pin stays input while used as clock
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         pin_out_q <= 1'b0;
      end else if (match & i_ch0_pin_c_cmp) begin
         pin_out_q <= ~pin_out_q;
      end
   end
   assign o_ch0_pin_c = pin_out_q;
   assign o_ch0_pin_c_oe = i_ch0_pin_c_cmp & (i_clk_sel != TAC_CK_A); // RULE10

   // Requests gated by enables; stay held while stopped
   assign o_match_irq = flg_q[TAC_FLG_MATCH] & i_match_en; // RULE11
   assign o_ovf_irq = flg_q[TAC_FLG_OVF] & i_ovf_en; // RULE14
   assign o_unf_irq = flg_q[TAC_FLG_UNF] & i_unf_en; // RULE14
   assign o_xfer_req = flg_q[TAC_FLG_MATCH] & i_match_en;
   assign o_rdata = rdata_q;
endmodule

// [tac_pkg.sv]
// Constants and types for the timer access contention block.
// Assumes a single 100 MHz clock and a synchronous active-low reset.
// Function
// [RULE1] Counter write beats a same-state increment
// [RULE2] Match register write suppresses compare match
// [RULE3] Buffered match transfers pre-write buffer contents
// [RULE4] Read during capture returns captured value
// [RULE5] Capture beats a match register write
// [RULE6] Capture buffer transfer beats buffer write
// [RULE7] Clear beats overflow; flags stay unset
// [RULE8] Counter write beats overflow; flags unset
// [RULE9] External clocks share four capture/compare pins
// [RULE10] Software avoids compare output on clock pins
// [RULE11] Pending requests held through module stop
// [RULE12] Software disables requests before module stop
// [RULE13] Flag cleared by write-zero after read, or transfer
// [RULE14] Overflow/underflow set flags; enables gate requests
// [RULE15] Counter clear beats a counter write
// [RULE16] Access takes two states, commit in second
// [RULE17] All contention settled within one state
package tac_pkg;
   localparam int TAC_W = 16;
   localparam logic [15:0] TAC_CNT_RST = 16'h0000;
   localparam logic [15:0] TAC_CNT_MAX = 16'hFFFF;
   localparam logic [15:0] TAC_GR_RST = 16'hFFFF;
   // Register select codes for the CPU access port
   localparam logic [1:0] TAC_SEL_CNT = 2'h0;
   localparam logic [1:0] TAC_SEL_GR = 2'h1;
   localparam logic [1:0] TAC_SEL_BUF = 2'h2;
   localparam logic [1:0] TAC_SEL_FLG = 2'h3;
   // Flag register bit positions
   localparam int TAC_FLG_MATCH = 0;
   localparam int TAC_FLG_OVF = 1;
   localparam int TAC_FLG_UNF = 2;
   // Clock source selection
   localparam logic [2:0] TAC_CK_INT = 3'h0;
   localparam logic [2:0] TAC_CK_A = 3'h1;
   localparam logic [2:0] TAC_CK_B = 3'h2;
   localparam logic [2:0] TAC_CK_C = 3'h3;
   localparam logic [2:0] TAC_CK_D = 3'h4;

   typedef enum logic [1:0] {
      TAC_ST_IDLE = 2'b00,
      TAC_ST_T1 = 2'b01,
      TAC_ST_T2 = 2'b10
   } tac_bus_e;
endpackage

// [tac_acc_if.sv]
// Interface carrying one decoded CPU access from the sequencer to the datapath.
// Assumes both ends share i_clk.
`timescale 1ns/1ns
interface tac_acc_if;
   logic t1;
   logic t2;
   logic wr;
   logic [1:0] sel;
   logic [15:0] wdata;
   modport seq (output t1, output t2, output wr, output sel, output wdata);
   modport dp (input t1, input t2, input wr, input sel, input wdata);
endinterface

// [tac_acc_seq.sv]
// Two-state CPU access sequencer: first state samples, second state commits.
// Assumes the requester holds its request fields until o_done.
`timescale 1ns/1ns
module tac_acc_seq
   import tac_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_req,
   input wire logic i_wr,
   input wire logic [1:0] i_sel,
   input wire logic [15:0] i_wdata,
   output logic o_done,
   tac_acc_if.seq acc
);
   tac_bus_e state_q;
   tac_bus_e state_d;

   // Idle, then T1, then T2, then idle again
   // A request still held at the commit edge must not start a second access
   always_comb begin
      case (state_q)
         TAC_ST_IDLE: state_d = i_req ? TAC_ST_T1 : TAC_ST_IDLE;
         TAC_ST_T1: state_d = TAC_ST_T2;
         TAC_ST_T2: state_d = TAC_ST_IDLE;
         default: state_d = TAC_ST_IDLE;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         state_q <= TAC_ST_IDLE;
      end else begin
         state_q <= state_d; // RULE16
      end
   end

   // Access phases as decoded strobes
   assign acc.t1 = (state_q == TAC_ST_T1);
   assign acc.t2 = (state_q == TAC_ST_T2);
   assign acc.wr = i_wr;
   assign acc.sel = i_sel;
   assign acc.wdata = i_wdata;
   assign o_done = acc.t2;
endmodule

// [tac_chk.sv]
// Checker for the timer's CPU access and request outputs.
// Assumes binding to tac_timer; one clock domain.
`timescale 1ns/1ns
module tac_chk
   import tac_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_req,
   input wire logic i_wr,
   input wire logic [2:0] i_clk_sel,
   input wire logic i_ovf_en,
   input wire logic i_match_en,
   input wire logic i_module_stop,
   input wire logic i_ch0_pin_c_cmp,
   input wire logic [15:0] o_rdata,
   input wire logic o_done,
   input wire logic o_ch0_pin_c_oe,
   input wire logic o_match_irq,
   input wire logic o_ovf_irq,
   input wire logic o_xfer_req
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   // Access handshake shape
   property p_pulse; o_done |=> !o_done; endproperty
   a_pulse: assert property (p_pulse) else $error("done longer than one cycle");
   property p_lat; $rose(i_req) |-> !o_done ##1 !o_done ##1 o_done; endproperty
   a_lat: assert property (p_lat) else $error("done not two cycles after request");
   property p_rd; !$stable(o_rdata) |-> o_done && !i_wr; endproperty
   a_rd: assert property (p_rd) else $error("read data moved outside a read");
   // Requests gated by enables; overflow request held through module stop
   property p_ovf; o_ovf_irq |-> i_ovf_en; endproperty
   a_ovf: assert property (p_ovf) else $error("overflow request without enable");
   property p_mat; o_match_irq |-> i_match_en; endproperty
   a_mat: assert property (p_mat) else $error("match request without enable");
   property p_xfer; o_xfer_req |-> i_match_en; endproperty
   a_xfer: assert property (p_xfer) else $error("transfer request without enable");
   property p_hold; o_ovf_irq && i_module_stop |=> o_ovf_irq || !i_module_stop || !i_ovf_en; endproperty
   a_hold: assert property (p_hold) else $error("request lost in module stop");
   // Clock A pin must not drive while it is a clock input
   property p_oe; i_clk_sel == TAC_CK_A |-> !o_ch0_pin_c_oe; endproperty
   a_oe: assert property (p_oe) else $error("pin driven while used as clock");
   property p_oe2; o_ch0_pin_c_oe |-> i_ch0_pin_c_cmp; endproperty
   a_oe2: assert property (p_oe2) else $error("pin driven without compare output");
   c_ovf: cover property (o_ovf_irq);
   c_xfer: cover property (o_xfer_req);
   c_rd: cover property (o_done && !i_wr);
endmodule
bind tac_timer tac_chk u_chk (.i_clk(i_clk), .i_rstn(i_rstn), .i_req(i_req), .i_wr(i_wr),
   .i_clk_sel(i_clk_sel), .i_ovf_en(i_ovf_en), .i_match_en(i_match_en), .i_module_stop(i_module_stop),
   .i_ch0_pin_c_cmp(i_ch0_pin_c_cmp), .o_rdata(o_rdata), .o_done(o_done), .o_ch0_pin_c_oe(o_ch0_pin_c_oe),
   .o_match_irq(o_match_irq), .o_ovf_irq(o_ovf_irq), .o_xfer_req(o_xfer_req));

// [tac_xfer_model.sv]
// Transfer controller model answering timer transfer requests.
// Assumes a level request that drops once acknowledged.
`timescale 1ns/1ns
module tac_xfer_model #(parameter int DLY = 2) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_req,
   output logic o_ack
);
   int cnt = 0;
   initial o_ack = 1'h0;
   // Ack DLY cycles after the request is seen; a large DLY models a busy controller
   always @(posedge i_clk) begin
      o_ack <= 1'h0;
      if (!i_rstn || !i_req || o_ack) begin
         cnt <= 0;
      end else if (cnt == DLY) begin
         o_ack <= 1'h1;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule

// [timer_access_contention_tb.sv]
// Testbench for tac_timer: CPU accesses, counting, clock pins, flags.
// Assumes the transfer controller model in tac_xfer_model.
`timescale 1ns/1ns
module timer_access_contention_tb;
   import tac_pkg::*;
   logic clk = 1'h0, rstn = 1'h0, req = 1'h0, wr = 1'h0, run = 1'h0, tick = 1'h0, capm = 1'h0, clrm = 1'h0;
   logic oen = 1'h1, men = 1'h0, stp = 1'h0, cmpo = 1'h1, ack, done, pout, oe, mirq, oirq, uirq, xreq;
   logic dn = 1'h0, bufm = 1'h0;
   logic [1:0] sel = 2'h0;
   logic [2:0] cs = TAC_CK_INT;
   logic [3:0] pins = 4'h0;
   logic [15:0] wd = 16'h0000, rd, v;
   logic [15:0] q[$];
   int mismatches = 0, cmp_count = 0;
   tac_timer u_dut (.i_clk(clk), .i_rstn(rstn), .i_req(req), .i_wr(wr), .i_sel(sel), .i_wdata(wd),
      .o_rdata(rd), .o_done(done), .i_run(run), .i_down(dn), .i_int_tick(tick), .i_clk_sel(cs),
      .i_capture_mode(capm), .i_buffer_mode(bufm), .i_clear_on_match(clrm), .i_ovf_en(oen), .i_unf_en(oen),
      .i_match_en(men), .i_module_stop(stp), .i_xfer_ack(ack), .i_ch0_pin_c(pins[0]), .i_ch0_pin_d(pins[1]),
      .i_ch1_pin_b(pins[2]), .i_ch2_pin_b(pins[3]), .i_ch0_pin_c_cmp(cmpo), .o_ch0_pin_c(pout),
      .o_ch0_pin_c_oe(oe), .o_match_irq(mirq), .o_ovf_irq(oirq), .o_unf_irq(uirq), .o_xfer_req(xreq));
   tac_xfer_model #(.DLY(2)) u_xfer (.i_clk(clk), .i_rstn(rstn), .i_req(xreq), .o_ack(ack));
   always #5 clk = ~clk;
   task automatic conclude();
      if (mismatches == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic cmp(input logic [15:0] g, input logic [15:0] e);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED %0t data %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk(input logic g, input logic e);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED %0t output %b expected %b", $time, g, e);
      end
   endtask
   // Request held until done is seen; released after the commit edge
   task automatic acc(input logic w, input logic [1:0] s, input logic [15:0] d);
      int n;
      @(posedge clk); #1;
      req = 1'h1; wr = w; sel = s; wd = d;
      n = 0;
      do begin @(negedge clk); n++; end while (done !== 1'h1 && n < 20);
      if (n >= 20) begin
         mismatches++;
         conclude();
      end else begin
         @(posedge clk); #1;
         req = 1'h0;
      end
   endtask
   task automatic rdx(input logic [1:0] s, input logic [15:0] e);
      q.push_back(e);
      acc(1'h0, s, 16'h0000);
   endtask
   task automatic tk(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Capture pulse on channel 0 pin C, raised n edges after the call
   task automatic pulse(input int n);
      tk(n);
      pins[0] = 1'h1;
      tk(2);
      pins = 4'h0;
   endtask
   // Read results checked in order of issue
   always @(negedge clk) if (done === 1'h1 && wr === 1'h0) cmp(rd, q.size() ? q.pop_front() : 16'hXXXX);
   initial begin
      void'($urandom(70));
      tk(8);
      rstn = 1'h1;
      for (int k = 0; k < 4; k++) rdx(k[1:0], (k == 1 || k == 2) ? TAC_GR_RST : 16'h0000);
      v = 16'($urandom);
      run = 1'h1; tick = 1'h1;
      acc(1'h1, TAC_SEL_CNT, v);
      run = 1'h0;
      rdx(TAC_SEL_CNT, v);
      // Overflow sets the flag; stop freezes it; write-zero after read clears it
      acc(1'h1, TAC_SEL_CNT, 16'hFFFD);
      run = 1'h1;
      tk(6);
      run = 1'h0;
      // General register still at its reset value, so the wrap is a match too
      rdx(TAC_SEL_FLG, 16'h0003);
      chk(oirq, 1'h1);
      oen = 1'h0;
      tk(1);
      chk(oirq, 1'h0);
      oen = 1'h1; stp = 1'h1;
      acc(1'h1, TAC_SEL_FLG, 16'h0000);
      chk(oirq, 1'h1);
      stp = 1'h0;
      rdx(TAC_SEL_FLG, 16'h0003);
      acc(1'h1, TAC_SEL_FLG, 16'h0000);
      rdx(TAC_SEL_FLG, 16'h0000);
      // Clear on match at the maximum value leaves overflow unset
      clrm = 1'h1;
      acc(1'h1, TAC_SEL_CNT, 16'hFFFD);
      run = 1'h1;
      tk(6);
      run = 1'h0; clrm = 1'h0;
      rdx(TAC_SEL_FLG, 16'h0001);
      men = 1'h1;
      tk(8);
      chk(xreq, 1'h0);
      rdx(TAC_SEL_FLG, 16'h0000);
      // Each external clock counts five rising edges on its own shared pin
      chk(oe, 1'h1);
      tick = 1'h0;
      for (int k = 1; k <= 4; k++) begin
         cs = k[2:0];
         acc(1'h1, TAC_SEL_CNT, 16'h0000);
         if (k == 1) chk(oe, 1'h0);
         cmpo = 1'h0;
         run = 1'h1;
         repeat (5) begin
            pins[k-1] = 1'h1;
            tk(2);
            pins = 4'h0;
            tk(2);
         end
         run = 1'h0;
         rdx(TAC_SEL_CNT, 16'h0005);
      end
      cmpo = 1'h1;
      // Capture in the sample state of a read is what the read returns
      cs = TAC_CK_INT; capm = 1'h1;
      acc(1'h1, TAC_SEL_CNT, v);
      fork
         rdx(TAC_SEL_GR, v);
         pulse(2);
      join
      // Capture in the commit state beats general and buffer writes
      acc(1'h1, TAC_SEL_CNT, 16'h0055);
      fork
         acc(1'h1, TAC_SEL_GR, 16'hA5A5);
         pulse(3);
      join
      rdx(TAC_SEL_GR, 16'h0055);
      bufm = 1'h1;
      acc(1'h1, TAC_SEL_CNT, 16'h0066);
      fork
         acc(1'h1, TAC_SEL_BUF, 16'h5A5A);
         pulse(3);
      join
      rdx(TAC_SEL_BUF, 16'h0055);
      rdx(TAC_SEL_GR, 16'h0066);
      // Match in the commit state of a same-value general write is dropped
      capm = 1'h0;
      bufm = 1'h0;
      men = 1'h0;
      acc(1'h1, TAC_SEL_GR, 16'h0010);
      acc(1'h1, TAC_SEL_CNT, 16'h000D);
      run = 1'h1;
      tick = 1'h1;
      acc(1'h1, TAC_SEL_GR, 16'h0010);
      run = 1'h0;
      rdx(TAC_SEL_FLG, 16'h0000);
      chk(pout, 1'h0);
      // Buffered match during a buffer write moves the old buffer contents
      bufm = 1'h1;
      acc(1'h1, TAC_SEL_BUF, 16'h0020);
      acc(1'h1, TAC_SEL_CNT, 16'h000D);
      run = 1'h1;
      acc(1'h1, TAC_SEL_BUF, 16'h0030);
      run = 1'h0;
      rdx(TAC_SEL_GR, 16'h0020);
      rdx(TAC_SEL_BUF, 16'h0030);
      rdx(TAC_SEL_FLG, 16'h0001);
      chk(pout, 1'h1);
      acc(1'h1, TAC_SEL_FLG, 16'h0000);
      // Underflow in the commit state of a counter write leaves the flag clear
      dn = 1'h1;
      acc(1'h1, TAC_SEL_CNT, 16'h0003);
      run = 1'h1;
      acc(1'h1, TAC_SEL_CNT, 16'h0001);
      run = 1'h0;
      rdx(TAC_SEL_CNT, 16'h0001);
      rdx(TAC_SEL_FLG, 16'h0000);
      run = 1'h1;
      tk(3);
      run = 1'h0;
      rdx(TAC_SEL_FLG, 16'h0004);
      chk(uirq, 1'h1);
      oen = 1'h0;
      stp = 1'h1;
      tk(1);
      chk(uirq, 1'h0);
      stp = 1'h0;
      tk(2);
      conclude();
   end
endmodule
